//--- crc_pkg.sv
// shared constants, types and helpers for the programmable checksum unit
package crc_pkg;
   // register byte offsets
   localparam int unsigned ADDR_W      = 5;
   localparam logic [4:0]  OFF_DATA    = 5'h00;
   localparam logic [4:0]  OFF_SCRATCH = 5'h04;
   localparam logic [4:0]  OFF_CTRL    = 5'h08;
   localparam logic [4:0]  OFF_SEED    = 5'h10;
   localparam logic [4:0]  OFF_COEF    = 5'h14;
   // reset values
   localparam logic [31:0] RST_DATA    = 32'hffffffff;
   localparam logic [31:0] RST_SEED    = 32'hffffffff;
   localparam logic [31:0] RST_COEF    = 32'h04c11db7;
   localparam logic [7:0]  RST_SCRATCH = 8'h00;
   localparam logic [31:0] FINAL_XOR   = 32'h00000000;
   // control field positions
   localparam int unsigned CTRL_CLEAR_BIT  = 0;
   localparam int unsigned CTRL_WIDTH_LSB  = 3;
   localparam int unsigned CTRL_REVIN_LSB  = 5;
   localparam int unsigned CTRL_REVOUT_BIT = 7;
   // timing and datapath
   localparam int unsigned CALC_MAX_CYCLES = 4;
   localparam int unsigned STEP_BITS       = 8;
   localparam logic [3:0]  STRB_ALL        = 4'hf;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

   typedef enum logic [1:0] {
      GW_32 = 2'b00,
      GW_16 = 2'b01,
      GW_8  = 2'b10,
      GW_7  = 2'b11
   } gen_width_t;

   typedef enum logic [1:0] {
      RI_NONE = 2'b00,
      RI_BYTE = 2'b01,
      RI_HALF = 2'b10,
      RI_WORD = 2'b11
   } rev_in_t;

   typedef enum logic {
      CALC_IDLE = 1'b0,
      CALC_RUN  = 1'b1
   } calc_state_t;

   typedef struct packed {
      logic       output_bit_reversal;
      rev_in_t    input_bit_reversal;
      gen_width_t generator_width_select;
   } ctrl_t;

   // reverse bit order inside each group of g bits
   function automatic logic [31:0] rev_group(input logic [31:0] x, input int unsigned g);
      logic [31:0] r;
      r = 32'h0;
      for (int unsigned i = 0; i < 32; i++) begin
         r[i] = x[(i / g) * g + (g - 1 - (i % g))];
      end
      return r;
   endfunction
endpackage

//--- crc_step.sv
// one multi-bit step of the modulo-2 division, msb first
`timescale 1ns/10ps
module crc_step
   import crc_pkg::*;
#(
   parameter int unsigned BITS = STEP_BITS
) (
   input  wire logic [31:0]     crc_in,
   input  wire logic [BITS-1:0] din,
   input  wire logic [31:0]     coef,
   input  wire gen_width_t      width,
   output logic [31:0]          crc_out
);
   logic [31:0] mask;
   logic [4:0]  top;
   logic [31:0] c;
   logic        fb;

   // narrow generators live in the low bits; upper remainder bits read zero
   always_comb begin
      unique case (width)
         GW_32: begin mask = 32'hffffffff; top = 5'd31; end
         GW_16: begin mask = 32'h0000ffff; top = 5'd15; end
         GW_8:  begin mask = 32'h000000ff; top = 5'd7;  end
         GW_7:  begin mask = 32'h0000007f; top = 5'd6;  end
      endcase
   end

   // shift each data bit through the remainder, msb first
   always_comb begin
      c  = crc_in & mask;
      fb = 1'b0;
      for (int i = BITS - 1; i >= 0; i--) begin
         fb = c[top] ^ din[i];
         c  = ((c << 1) & mask) ^ (fb ? (coef & mask) : 32'h0);
      end
      crc_out = c;
   end
endmodule // crc_step

//--- crc_unit.sv
// checksum unit: axi4-lite register slave, input/output reversal, step sequencer
`timescale 1ns/10ps
module crc_unit
   import crc_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready
);
   logic [31:0]       data_q;
   logic [7:0]        scratch_q;
   ctrl_t             ctrl_q;
   logic [31:0]       seed_q;
   logic [31:0]       coef_q;
   logic              clear_q;
   calc_state_t       state_q;
   logic [31:0]       shift_q;
   logic [2:0]        left_q;
   logic              aw_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic              w_have_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              ar_have_q;
   logic [ADDR_W-1:0] araddr_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic [4:0]        wr_off;
   logic [4:0]        rd_off;
   logic              wr_fire;
   logic              wr_full;
   logic              rd_fire;
   logic              data_go;
   logic [2:0]        nbytes;
   logic [1:0]        lane;
   logic [5:0]        pad;
   logic [31:0]       item;
   logic [31:0]       aligned;
   int unsigned       grp;
   logic [31:0]       step_out;
   logic [31:0]       out_val;

   // handshake outputs straight from the holding flags
   assign awready = !aw_have_q;
   assign wready  = !w_have_q;
   assign arready = !ar_have_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // decode on word boundaries; low two address bits are ignored
   assign wr_off  = {awaddr_q[4:2], 2'b00};
   assign rd_off  = {araddr_q[4:2], 2'b00};
   assign wr_full = (wstrb_q == STRB_ALL);

   // writes wait while a step runs or a clear is pending, so data stays ordered
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q && (state_q == CALC_IDLE) && !clear_q;
   assign data_go = wr_fire && (wr_off == OFF_DATA) && (nbytes != 3'd0);

   // a busy data read is held back until the remainder is final
   assign rd_fire = ar_have_q && !rvalid_q &&
                    !((rd_off == OFF_DATA) && ((state_q == CALC_RUN) || clear_q));

   // address and data channels are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awaddr_q  <= '0;
         w_have_q  <= 1'b0;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
      end else begin
         if (awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response; partial strobes outside the data port are refused
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         if (wr_off == OFF_DATA) begin
            bresp_q <= (nbytes != 3'd0) ? RESP_OKAY : RESP_SLVERR;
         end else if (!wr_full) begin
            bresp_q <= RESP_SLVERR;
         end else begin
            unique case (wr_off)
               OFF_SCRATCH, OFF_CTRL, OFF_SEED, OFF_COEF: bresp_q <= RESP_OKAY;
               default:                                   bresp_q <= RESP_SLVERR;
            endcase
         end
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // size and lane of a data write from its strobes
   always_comb begin
      case (wstrb_q)
         4'hf:    begin nbytes = 3'd4; lane = 2'd0; end
         4'h3:    begin nbytes = 3'd2; lane = 2'd0; end
         4'hc:    begin nbytes = 3'd2; lane = 2'd2; end
         4'h1:    begin nbytes = 3'd1; lane = 2'd0; end
         4'h2:    begin nbytes = 3'd1; lane = 2'd1; end
         4'h4:    begin nbytes = 3'd1; lane = 2'd2; end
         4'h8:    begin nbytes = 3'd1; lane = 2'd3; end
         default: begin nbytes = 3'd0; lane = 2'd0; end
      endcase
   end

   // only the written bits enter, reversed, then msb-aligned for the steps
   always_comb begin
      pad  = 6'd32 - {nbytes, 3'b000};
      item = (wdata_q >> {lane, 3'b000}) & (32'hffffffff >> pad);
      unique case (ctrl_q.input_bit_reversal)
         RI_NONE: grp = 32'd0;
         RI_BYTE: grp = 32'd8;
         RI_HALF: grp = 32'd16;
         RI_WORD: grp = 32'd32;
      endcase
      // a group never spans more than the written item
      if (grp > 32'({nbytes, 3'b000})) begin
         grp = 32'({nbytes, 3'b000});
      end
      if (grp == 32'd0) begin
         aligned = item << pad;
      end else begin
         aligned = rev_group(item, grp) << pad;
      end
   end

   // one byte per cycle keeps a full word inside four cycles
   crc_step #(
      .BITS (STEP_BITS)
   ) u_step (
      .crc_in  (data_q),
      .din     (shift_q[31 -: STEP_BITS]),
      .coef    (coef_q),
      .width   (ctrl_q.generator_width_select),
      .crc_out (step_out)
   );

   // step sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= CALC_IDLE;
         shift_q <= 32'h0;
         left_q  <= 3'd0;
      end else begin
         unique case (state_q)
            CALC_IDLE: begin
               if (data_go) begin
                  state_q <= CALC_RUN;
                  shift_q <= aligned;
                  left_q  <= nbytes;
               end
            end
            CALC_RUN: begin
               shift_q <= shift_q << STEP_BITS;
               left_q  <= left_q - 3'd1;
               if (left_q == 3'd1) begin
                  state_q <= CALC_IDLE;
               end
            end
         endcase
      end
   end

   // remainder: seeded by a clear, chained from itself otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_q <= RST_DATA;
      end else if (clear_q) begin
         data_q <= seed_q;
      end else if (state_q == CALC_RUN) begin
         data_q <= step_out;
      end
   end

   // clear request lives one cycle, so bit 0 always reads back as zero afterwards
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= wr_fire && wr_full && wr_off == OFF_CTRL && wdata_q[CTRL_CLEAR_BIT];
      end
   end

   // software-owned configuration; scratch is untouched by the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scratch_q <= RST_SCRATCH;
         ctrl_q    <= '0;
         seed_q    <= RST_SEED;
         coef_q    <= RST_COEF;
      end else if (wr_fire && wr_full) begin
         unique case (wr_off)
            OFF_SCRATCH: scratch_q <= wdata_q[7:0];
            OFF_CTRL: begin
               ctrl_q.output_bit_reversal    <= wdata_q[CTRL_REVOUT_BIT];
               ctrl_q.input_bit_reversal     <= rev_in_t'(wdata_q[CTRL_REVIN_LSB +: 2]);
               ctrl_q.generator_width_select <=
                  gen_width_t'(wdata_q[CTRL_WIDTH_LSB +: 2]);
            end
            OFF_SEED: seed_q <= wdata_q;
            OFF_COEF: coef_q <= wdata_q;
            default: ;
         endcase
      end
   end

   // presented result: optional word reversal, zero final xor
   assign out_val = (ctrl_q.output_bit_reversal ? rev_group(data_q, 32'd32) : data_q)
                    ^ FINAL_XOR;

   // read address capture and registered read data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_have_q <= 1'b0;
         araddr_q  <= '0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (arvalid && !ar_have_q) begin
            ar_have_q <= 1'b1;
            araddr_q  <= araddr;
         end else if (rd_fire) begin
            ar_have_q <= 1'b0;
         end
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            unique case (rd_off)
               OFF_DATA:    rdata_q <= out_val;
               OFF_SCRATCH: rdata_q <= {24'h0, scratch_q};
               OFF_CTRL:    rdata_q <= {24'h0, ctrl_q, 2'b00, clear_q};
               OFF_SEED:    rdata_q <= seed_q;
               OFF_COEF:    rdata_q <= coef_q;
               default: begin
                  rdata_q <= 32'h0;
                  rresp_q <= RESP_SLVERR;
               end
            endcase
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_calc_bound: assert property ($rose(state_q == CALC_RUN) |->
      ##[1:4] state_q == CALC_IDLE) else $error("calculation exceeded four cycles");
   chk_byte_step: assert property (data_go && nbytes == 3'd1 |=>
      state_q == CALC_RUN ##1 state_q == CALC_IDLE) else $error("byte write step count wrong");
   chk_seed_load: assert property (clear_q |=> data_q == $past(seed_q))
      else $error("clear did not load the seed");
   chk_clear_self: assert property (clear_q |=> !clear_q && $past(state_q) == CALC_IDLE)
      else $error("clear request did not self-clear");
   chk_scratch_keep: assert property (clear_q |=> $stable(scratch_q))
      else $error("scratch changed on clear");
   chk_read_stall: assert property ($rose(rvalid_q) && rd_off == OFF_DATA |->
      $past(state_q) == CALC_IDLE && !$past(clear_q)) else $error("data read taken while busy");
   chk_out_rev: assert property (rd_fire && rd_off == OFF_DATA &&
      ctrl_q.output_bit_reversal |=> rdata_q == rev_group($past(data_q), 32'd32))
      else $error("output reversal wrong");
   chk_partial_refuse: assert property (wr_fire && !wr_full && wr_off == OFF_SEED |=>
      $stable(seed_q) && bresp_q == RESP_SLVERR)
      else $error("partial write to seed not refused");
   chk_reset_vals: assert property ($rose(aresetn) |->
      data_q == RST_DATA && coef_q == RST_COEF) else $error("wrong reset values");

   cov_word_write: cover property (data_go && nbytes == 3'd4);
   cov_byte_write: cover property (data_go && nbytes == 3'd1);
   cov_clear:      cover property (clear_q);
   cov_stalled_rd: cover property (ar_have_q && rd_off == OFF_DATA && state_q == CALC_RUN);
endmodule // crc_unit

//--- programmable_crc_unit_bench.sv
// self-checking bench for the programmable checksum unit over axi4-lite
`timescale 1ns/10ps
module programmable_crc_unit_bench
   import crc_pkg::*;
;
   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr;
   logic [ADDR_W-1:0] araddr;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [31:0]       wdata;
   logic [31:0]       rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp;
   logic [1:0]        rresp;
   logic [31:0]       rd;
   logic [1:0]        rsp;
   int                mismatches = 0;
   int                tests_run  = 0;
   int                cycles     = 0;

   // 50 mhz clock
   initial aclk = 1'b0;
   always #10 aclk = ~aclk;

   crc_unit crc_unit_i (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready)
   );

   // reference remainder, msb first, upper bits masked for narrow widths
   function automatic logic [31:0] ref_step(logic [31:0] c, logic [31:0] d, int n,
                                            logic [31:0] p, int w);
      logic [31:0] m;
      logic        fb;
      m = (w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
      for (int i = n - 1; i >= 0; i--) begin
         fb = c[w-1] ^ d[i];
         c = ((c << 1) & m) ^ (fb ? (p & m) : 32'h0);
      end
      return c;
   endfunction

   // group reversal by index xor, valid for power-of-two groups only
   function automatic logic [31:0] ref_rev(logic [31:0] x, int g);
      logic [31:0] r;
      for (int i = 0; i < 32; i++) begin
         r[i ^ (g - 1)] = x[i];
      end
      return r;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, want);
      end
   endtask

   // one write; the trailing edge keeps two requests from sharing a time step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] want, input string what);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd  = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      check(rd, want, what);
   endtask

   task automatic t_reset;
      rchk(OFF_DATA, 32'hffffffff, "data reset");
      rchk(OFF_SCRATCH, 32'h0, "scratch reset");
      rchk(OFF_CTRL, 32'h0, "control reset");
      rchk(OFF_SEED, 32'hffffffff, "seed reset");
      rchk(OFF_COEF, 32'h04c11db7, "coefficient reset");
      rchk(5'h0c, 32'h0, "unmapped read");
      check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped resp");
      $display("test reset values done");
   endtask

   // nine byte writes straight from reset, read issued once the last has finished
   task automatic t_standard;
      for (int i = 0; i < 9; i++) begin
         wr(OFF_DATA, 32'h31 + i, 4'h1);
      end
      check({30'h0, rsp}, {30'h0, RESP_OKAY}, "byte write resp");
      rchk(OFF_DATA, 32'h0376e6e7, "standard check value");
      $display("test standard string done");
   endtask

   task automatic t_reverse;
      logic [31:0] e;
      for (int o = 0; o < 2; o++) begin
         for (int m = 0; m < 4; m++) begin
            wr(OFF_CTRL, 32'(o * 128 + m * 32 + 1), STRB_ALL);
            rchk(OFF_CTRL, 32'(o * 128 + m * 32), "control fields");
            wr(OFF_DATA, 32'h12345678, STRB_ALL);
            e = ref_step(32'hffffffff, ref_rev(32'h12345678, m == 0 ? 1 : 4 << m), 32,
                         32'h04c11db7, 32);
            if (o == 1) e = ref_rev(e, 32);
            rchk(OFF_DATA, e, "reversed result");
         end
      end
      wr(OFF_CTRL, 32'h0, STRB_ALL);
      $display("test reversal modes done");
   endtask

   // the odd coefficient shows whether only its low bits are used
   task automatic t_width;
      int w;
      wr(OFF_COEF, 32'h8d2f1021, STRB_ALL);
      rchk(OFF_COEF, 32'h8d2f1021, "coefficient written");
      for (int k = 0; k < 4; k++) begin
         w = (k == 3) ? 7 : (32 >> k);
         wr(OFF_CTRL, 32'(k * 8 + 1), STRB_ALL);
         wr(OFF_DATA, 32'h5a, 4'h1);
         rchk(OFF_DATA, ref_step(32'hffffffff, 32'h5a, 8, 32'h8d2f1021, w),
              "narrow width");
      end
      wr(OFF_COEF, 32'h04c11db7, STRB_ALL);
      wr(OFF_CTRL, 32'h0, STRB_ALL);
      $display("test generator widths done");
   endtask

   task automatic t_scratch;
      wr(OFF_SCRATCH, 32'h123456c3, STRB_ALL);
      wr(OFF_SEED, 32'h13579bdf, STRB_ALL);
      wr(OFF_CTRL, 32'h1, STRB_ALL);
      rchk(OFF_DATA, 32'h13579bdf, "seed loaded");
      rchk(OFF_SCRATCH, 32'hc3, "scratch kept");
      rchk(OFF_CTRL, 32'h0, "clear bit self-clears");
      wr(OFF_DATA, 32'h77, 4'h1);
      rchk(OFF_DATA, ref_step(32'h13579bdf, 32'h77, 8, 32'h04c11db7, 32), "seeded step");
      wr(OFF_SEED, 32'hffffffff, STRB_ALL);
      $display("test scratch and seed done");
   endtask

   task automatic t_refuse;
      logic [31:0] e;
      wr(OFF_CTRL, 32'h81, 4'h3);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "narrow control write");
      rchk(OFF_CTRL, 32'h0, "control untouched");
      wr(OFF_SEED, 32'h0, 4'h3);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "narrow seed write");
      rchk(OFF_SEED, 32'hffffffff, "seed untouched");
      wr(OFF_CTRL, 32'h1, STRB_ALL);
      wr(OFF_DATA, 32'h0, 4'h6);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "odd strobe data write");
      wr(5'h18, 32'h5, STRB_ALL);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
      rchk(OFF_DATA, 32'hffffffff, "data untouched");
      wr(OFF_DATA, 32'habcd0000, 4'hc);
      e = ref_step(32'hffffffff, 32'habcd, 16, 32'h04c11db7, 32);
      rchk(OFF_DATA, e, "upper half-word lane");
      wr(OFF_CTRL, 32'h0, STRB_ALL);
      rchk(OFF_DATA, e, "zero clear bit ignored");
      $display("test refused accesses done");
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         $display("CHECK FAILED at %0t: timeout", $time);
         report_and_stop;
      end
   end

   initial begin
      aresetn = 1'b0;
      awaddr  = '0;
      araddr  = '0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      wdata   = 32'h0;
      wstrb   = 4'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_standard;
      t_reverse;
      t_width;
      t_scratch;
      t_refuse;
      report_and_stop;
   end
endmodule // programmable_crc_unit_bench
